// [spi_master_slave_core.sv]
// Purpose: Byte-wide serial peripheral unit, master or slave
// Assumes: Pins are split into input, output and enable; the pad resolves them
// Notes:   Transmit bytes arrive through a 32-entry FIFO
`timescale 1ns/1ps
`default_nettype none

module spi_master_slave_core #(
    parameter int FIFO_DEPTH_P = 32
) (
    input  wire logic                       clock_i,
    input  wire logic                       rstn_i,
    input  wire spi_core_pkg::cfg_t         cfg_i,
    input  wire spi_core_pkg::pin_t         pins_i,
    output var spi_core_pkg::pin_t          pins_o,
    output var spi_core_pkg::pin_t          pins_oe_o,
    input  wire logic [7:0]                 tx_data_i,
    input  wire logic                       tx_valid_i,
    output logic                            tx_ready_o,
    output logic [7:0]                      rx_data_o,
    input  wire logic                       rx_read_i,
    input  wire logic                       fault_clear_i,
    output var spi_core_pkg::status_t       status_o,
    input  wire logic                       stop_light_i,
    input  wire logic                       stop_deep_i
);
    import spi_core_pkg::*;

    // ***************************************************************
    // State
    // ***************************************************************
    typedef struct packed {
        pin_t              sync1;
        pin_t              sync2;
        logic              sclk_prev;
        phase_t            phase;
        logic [DIV_W-1:0]  div_cnt;
        logic [3:0]        edge_cnt;
        logic [2:0]        bit_cnt;
        logic [DATA_W-1:0] shifter;
        logic [DATA_W-1:0] txb;
        logic              txb_full;
        logic [DATA_W-1:0] rxb;
        logic              rx_full;
        logic              mode_fault;
        logic              sclk_lvl;
        logic              dout;
        pin_t              pin_o;
        pin_t              pin_oe;
        status_t           status;
    } core_st_t;

    localparam core_st_t ST_RESET = '{
        sync1:      PINS_RESET,
        sync2:      PINS_RESET,
        sclk_prev:  1'h0,
        phase:      PH_IDLE,
        div_cnt:    '0,
        edge_cnt:   4'h0,
        bit_cnt:    3'h0,
        shifter:    DATA_RESET,
        txb:        DATA_RESET,
        txb_full:   1'h0,
        rxb:        DATA_RESET,
        rx_full:    1'h0,
        mode_fault: 1'h0,
        sclk_lvl:   1'h0,
        dout:       1'h0,
        pin_o:      PINS_RESET,
        pin_oe:     PINS_RESET,
        status:     STATUS_RESET
    };

    core_st_t st;
    core_st_t next_st;

    // ***************************************************************
    // Transmit FIFO
    // ***************************************************************
    logic [DATA_W-1:0] fifo_data;
    logic              fifo_valid;
    logic              fifo_take;

    assign fifo_take = cfg_i.unit_enable & ~st.txb_full & ~stop_light_i & ~stop_deep_i;

    spi_tx_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH_P)
    ) u_tx_fifo (
        .clock_i     (clock_i),
        .rstn_i      (rstn_i),
        .clear_i     (stop_deep_i),
        .in_data_i   (tx_data_i),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (tx_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_take)
    );

    // ***************************************************************
    // Helpers
    // ***************************************************************
    function automatic logic out_bit(input logic [DATA_W-1:0] sh, input logic lsbf);
        return lsbf ? sh[0] : sh[DATA_W-1];
    endfunction

    function automatic logic [DATA_W-1:0] shift_in(input logic [DATA_W-1:0] sh,
                                                   input logic lsbf, input logic din);
        return lsbf ? {din, sh[DATA_W-1:1]} : {sh[DATA_W-2:0], din};
    endfunction

    // ***************************************************************
    // Next state
    // ***************************************************************
    always_comb begin
        logic              master;
        logic              sw;
        logic              m_din;
        logic              s_din;
        logic              selected;
        logic              sclk_chg;
        logic              lead;
        logic              trail;
        logic              sample;
        logic              fault_in;
        logic [DIV_W-1:0]  pre1;
        logic [DIV_W-1:0]  half;
        logic [DATA_W-1:0] nsh;

        master   = cfg_i.master_select;
        sw       = cfg_i.single_wire_select;
        m_din    = sw ? st.sync2.mosi : st.sync2.miso;
        s_din    = sw ? st.sync2.miso : st.sync2.mosi;
        selected = ~st.sync2.select_n;
        sclk_chg = st.sync2.shift_clock_pin != st.sclk_prev;
        lead     = sclk_chg & (st.sync2.shift_clock_pin != cfg_i.clock_polarity);
        trail    = sclk_chg & (st.sync2.shift_clock_pin == cfg_i.clock_polarity);
        fault_in = master & cfg_i.fault_detect_enable & ~cfg_i.select_output_enable & selected;
        pre1     = DIV_W'(cfg_i.prescale_field) + 11'h001;
        half     = pre1 << cfg_i.rate_select_field;
        sample   = 1'h0;
        nsh      = st.shifter;

        next_st           = st;
        next_st.sync1     = pins_i;
        next_st.sync2     = st.sync1;
        next_st.sclk_prev = st.sync2.shift_clock_pin;

        // Holding buffers
        if (fifo_take & fifo_valid) begin
            next_st.txb      = fifo_data;
            next_st.txb_full = 1'h1;
        end
        next_st.rx_full = st.rx_full & ~rx_read_i;
        next_st.mode_fault = st.mode_fault & ~fault_clear_i;

        // ***********************************************************
        // Transfer engine
        // ***********************************************************
        case (st.phase)
            PH_IDLE: begin
                next_st.sclk_lvl = cfg_i.clock_polarity;
                next_st.div_cnt  = '0;
                next_st.edge_cnt = 4'h0;
                next_st.bit_cnt  = 3'h0;
                if (master) begin
                    if (st.txb_full & ~st.mode_fault & ~fault_in) begin
                        next_st.shifter  = st.txb;
                        next_st.txb_full = 1'h0;
                        next_st.dout     = out_bit(st.txb, cfg_i.lsb_first_select);
                        next_st.phase    = PH_MASTER;
                    end
                end else if (selected) begin
                    next_st.shifter  = st.txb;
                    next_st.txb_full = 1'h0;
                    next_st.dout     = out_bit(st.txb, cfg_i.lsb_first_select);
                    next_st.phase    = PH_SLAVE;
                end
            end
            PH_MASTER: begin
                if (st.div_cnt == half - 11'h001) begin
                    next_st.div_cnt  = '0;
                    next_st.sclk_lvl = ~st.sclk_lvl;
                    next_st.edge_cnt = st.edge_cnt + 4'h1;
                    sample = st.edge_cnt[0] == cfg_i.clock_phase;
                    if (sample) begin
                        nsh = shift_in(st.shifter, cfg_i.lsb_first_select, m_din);
                        next_st.shifter = nsh;
                    end else if (st.edge_cnt != LAST_EDGE) begin
                        next_st.dout = out_bit(st.shifter, cfg_i.lsb_first_select);
                    end
                    if (st.edge_cnt == LAST_EDGE) begin
                        next_st.rxb     = nsh;
                        next_st.rx_full = 1'h1;
                        next_st.phase   = PH_IDLE;
                    end
                end else begin
                    next_st.div_cnt = st.div_cnt + 11'h001;
                end
            end
            PH_SLAVE: begin
                if (!selected) begin
                    next_st.phase = PH_IDLE;
                end else if (lead | trail) begin
                    sample = cfg_i.clock_phase ? trail : lead;
                    if (sample) begin
                        nsh = shift_in(st.shifter, cfg_i.lsb_first_select, s_din);
                        next_st.shifter = nsh;
                        next_st.bit_cnt = st.bit_cnt + 3'h1;
                        if (st.bit_cnt == LAST_BIT) begin
                            next_st.rxb     = nsh;
                            next_st.rx_full = 1'h1;
                            next_st.phase   = PH_IDLE;
                        end
                    end else begin
                        next_st.dout = out_bit(st.shifter, cfg_i.lsb_first_select);
                    end
                end
            end
            default: begin
                next_st.phase = PH_IDLE;
            end
        endcase

        // Mode fault aborts a master transfer
        if (fault_in) begin
            next_st.mode_fault = 1'h1;
            next_st.phase      = PH_IDLE;
            next_st.sclk_lvl   = cfg_i.clock_polarity;
        end

        // Leaving master mode mid-byte ends the transfer
        if (master != (st.phase == PH_MASTER) && st.phase != PH_IDLE) begin
            next_st.phase = PH_IDLE;
        end

        // ***********************************************************
        // Pin steering
        // ***********************************************************
        next_st.pin_o  = PINS_RESET;
        next_st.pin_oe = PINS_RESET;
        if (master) begin
            next_st.pin_o.shift_clock_pin  = next_st.sclk_lvl;
            next_st.pin_oe.shift_clock_pin = 1'h1;
            next_st.pin_o.mosi             = next_st.dout;
            next_st.pin_oe.mosi            = sw ? cfg_i.single_wire_drive_enable : 1'h1;
            if (cfg_i.fault_detect_enable & cfg_i.select_output_enable) begin
                next_st.pin_o.select_n  = next_st.phase != PH_MASTER;
                next_st.pin_oe.select_n = 1'h1;
            end
        end else begin
            next_st.pin_o.miso  = next_st.dout;
            next_st.pin_oe.miso = sw ? cfg_i.single_wire_drive_enable : selected;
        end

        // ***********************************************************
        // Disable, stop
        // ***********************************************************
        if (!cfg_i.unit_enable) begin
            next_st.phase      = PH_IDLE;
            next_st.txb_full   = 1'h0;
            next_st.txb        = DATA_RESET;
            next_st.rxb        = DATA_RESET;
            next_st.rx_full    = 1'h0;
            next_st.mode_fault = 1'h0;
            next_st.shifter    = DATA_RESET;
            next_st.dout       = 1'h0;
            next_st.sclk_lvl   = cfg_i.clock_polarity;
            next_st.pin_o      = PINS_RESET;
            next_st.pin_oe     = PINS_RESET;
        end

        next_st.status.receive_full_flag   = next_st.rx_full;
        next_st.status.transmit_empty_flag = ~next_st.txb_full;
        next_st.status.mode_fault_flag     = next_st.mode_fault;
        next_st.status.busy                = next_st.phase != PH_IDLE;

        if (stop_light_i) begin
            next_st = st;
        end
        if (stop_deep_i) begin
            next_st = ST_RESET;
        end
    end

    // ***************************************************************
    // State register
    // ***************************************************************
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    assign pins_o    = st.pin_o;
    assign pins_oe_o = st.pin_oe;
    assign rx_data_o = st.rxb;
    assign status_o  = st.status;

endmodule // spi_master_slave_core

`default_nettype wire

// [spi_core_pkg.sv]
// Purpose: Shared types and constants for the serial peripheral core
// Assumes: One bus clock at 100 MHz, synchronous active-low reset
// Notes:   Control and status bits travel as packed structs
//
// Functional notes
// - Only a master starts transfers; a slave shifts only on the incoming clock.
// - Master shifts out and in at once, swapping both shift registers.
// - Data write fills transmit holding buffer; it enters shifter at transfer start.
// - Completed received byte is copied to a receive holding buffer for reading.
// - Master drives clock pin, drives MOSI, samples MISO.
// - Slave takes clock pin, drives MISO, samples MOSI.
// - Bit rate starts from bus clock divided by prescale 1 to 8.
// - Prescaler output further divided by power of two, 2 to 256.
// - When unit disabled all four pins are released.
// - Two-wire mode: MOSI output as master, input as slave.
// - Two-wire mode: MISO input as master, output as slave.
// - Single-wire master: MOSI is bidirectional data, MISO released.
// - Single-wire slave: MISO is bidirectional data, MOSI released.
// - Clock pin is input as slave, output as master.
// - Select pin: slave input; master free, fault input or automatic output.
// - Inactive in stop; deepest stop returns in reset state.
// - Light stop holds all state and resumes; reset exit resets. The transmit FIFO still accepts writes in light stop.
// - Five eight-bit software-visible registers of options, rate, status, data.
// - Clock polarity selects idle-low or idle-high shift clock.
// - Clock phase puts first edge mid-bit or at start of bit.
// - LSB-first select chooses shift order for both directions.
// - Disabling aborts transfer, empties buffers, sets transmit-empty, clears receive-full. The transmit FIFO keeps its entries.

package spi_core_pkg;

    // ***************************************************************
    // Sizes and timing
    // ***************************************************************
    localparam int DATA_W     = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int DIV_W      = 11;
    localparam int EDGES      = 16;
    localparam logic [3:0] LAST_EDGE = 4'hF;
    localparam logic [2:0] LAST_BIT  = 3'h7;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

    // ***************************************************************
    // Transfer phase
    // ***************************************************************
    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_MASTER = 2'b01,
        PH_SLAVE  = 2'b10
    } phase_t;

    // ***************************************************************
    // Carriers
    // ***************************************************************
    typedef struct packed {
        logic       unit_enable;
        logic       master_select;
        logic       clock_polarity;
        logic       clock_phase;
        logic       lsb_first_select;
        logic       select_output_enable;
        logic       fault_detect_enable;
        logic       single_wire_select;
        logic       single_wire_drive_enable;
        logic [2:0] prescale_field;
        logic [2:0] rate_select_field;
    } cfg_t;

    typedef struct packed {
        logic shift_clock_pin;
        logic mosi;
        logic miso;
        logic select_n;
    } pin_t;

    typedef struct packed {
        logic receive_full_flag;
        logic transmit_empty_flag;
        logic mode_fault_flag;
        logic busy;
    } status_t;

    localparam pin_t    PINS_RESET   = '{default: 1'h0};
    localparam status_t STATUS_RESET = '{receive_full_flag: 1'h0, transmit_empty_flag: 1'h1,
                                         mode_fault_flag: 1'h0, busy: 1'h0};

endpackage

// [spi_tx_fifo.sv]
// Purpose: Transmit FIFO feeding the data register
// Assumes: DEPTH is a power of two
// Notes:   Ready and valid are registered
`timescale 1ns/1ps
`default_nettype none

module spi_tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    input  wire logic             clear_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
        logic                        in_ready;
        logic                        out_valid;
    } fifo_st_t;

    fifo_st_t st;
    fifo_st_t next_st;

    // ***************************************************************
    // Next state
    // ***************************************************************
    always_comb begin
        logic push;
        logic pop;
        push    = in_valid_i & st.in_ready;
        pop     = out_ready_i & st.out_valid;
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data_i;
            next_st.wr         = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (clear_i) begin
            next_st.wr  = '0;
            next_st.rd  = '0;
            next_st.cnt = '0;
        end
        next_st.in_ready  = next_st.cnt != (AW+1)'(DEPTH);
        next_st.out_valid = next_st.cnt != '0;
    end

    // ***************************************************************
    // State register
    // ***************************************************************
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            st          <= '0;
            st.in_ready <= 1'h1;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready_o  = st.in_ready;
    assign out_valid_o = st.out_valid;
    assign out_data_o  = st.mem[st.rd];

endmodule // spi_tx_fifo

`default_nettype wire

// [spi_core_asserts.sv]
// Purpose: Port-level checks of the serial core
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the core below the module
`timescale 1ns/1ps
`default_nettype none
module spi_core_asserts (
    input wire logic                  clock_i,
    input wire logic                  rstn_i,
    input wire spi_core_pkg::cfg_t    cfg_i,
    input wire spi_core_pkg::pin_t    pins_i,
    input wire spi_core_pkg::pin_t    pins_o,
    input wire spi_core_pkg::pin_t    pins_oe_o,
    input wire spi_core_pkg::status_t status_o,
    input wire logic                  stop_light_i,
    input wire logic                  stop_deep_i
);
    import spi_core_pkg::*;
    // ***************************************************************
    // Mode helpers and sequences
    // ***************************************************************
    wire run  = cfg_i.unit_enable & ~stop_light_i & ~stop_deep_i;
    wire mst  = run & cfg_i.master_select;
    wire slv  = run & ~cfg_i.master_select;
    wire asel = cfg_i.fault_detect_enable & cfg_i.select_output_enable;
    wire off  = ~cfg_i.unit_enable & ~stop_light_i;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    sequence s_mst2; (mst && !cfg_i.single_wire_select)[*2]; endsequence
    sequence s_swm2; (mst && cfg_i.single_wire_select)[*2]; endsequence
    sequence s_unsel; (slv && pins_i.select_n)[*6]; endsequence
    dis_release_a: assert property (off |=> pins_oe_o == '0)
        else $error("pins driven while disabled");
    dis_flags_a: assert property (off |=> status_o.transmit_empty_flag && !status_o.receive_full_flag)
        else $error("flags wrong while disabled");
    mst_pins_a: assert property (s_mst2 |-> pins_oe_o.shift_clock_pin && pins_oe_o.mosi && !pins_oe_o.miso)
        else $error("master pin directions wrong");
    slv_pins_a: assert property (slv[*2] |-> !pins_oe_o.shift_clock_pin && !pins_oe_o.mosi)
        else $error("slave pin directions wrong");
    sw_mst_a: assert property (s_swm2 |-> pins_oe_o.mosi == $past(cfg_i.single_wire_drive_enable) && !pins_oe_o.miso)
        else $error("single wire master direction wrong");
    sel_pin_a: assert property (mst[*2] |-> pins_oe_o.select_n == $past(asel))
        else $error("select pin direction wrong");
    slv_idle_a: assert property (s_unsel |-> !status_o.busy)
        else $error("unselected slave busy");
    light_freeze_a: assert property (stop_light_i && !stop_deep_i |=> $stable(pins_o) && $stable(status_o))
        else $error("state moved in light stop");
    deep_reset_a: assert property (stop_deep_i && !stop_light_i |=> status_o == STATUS_RESET && pins_oe_o == '0)
        else $error("deep stop left state");
endmodule // spi_core_asserts
bind spi_master_slave_core spi_core_asserts spi_core_asserts_i (.clock_i, .rstn_i, .cfg_i, .pins_i, .pins_o,
    .pins_oe_o, .status_o, .stop_light_i, .stop_deep_i);
`default_nettype wire

// [spi_slave_model.sv]
// Purpose: Behavioural external slave, clock idle low, sample on rise
// Assumes: Master supplies clock and select
// Notes:   Released data line shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
    input wire logic       sck_i,
    input wire logic       mosi_i,
    input wire logic       ss_n_i,
    input wire logic [7:0] tx_byte_i,
    output var logic       miso_o,
    output var logic [7:0] rx_byte_o
);
    logic [7:0] shift = 8'h00;
    initial rx_byte_o = 8'h00;
    initial miso_o = 1'b0;
    // Loads on select; acts on the supplied clock only while selected
    always @(negedge ss_n_i) shift = tx_byte_i;
    always @(posedge sck_i) if (!ss_n_i) rx_byte_o = {rx_byte_o[6:0], mosi_i};
    always @(negedge sck_i) if (!ss_n_i) shift = {shift[6:0], shift[7]};
    always @(ss_n_i or shift) miso_o = ss_n_i ? ~miso_o : shift[7];
endmodule // spi_slave_model
`default_nettype wire

// [tb_spi_master_slave_core.sv]
// Purpose: Self-checking bench for the serial core
// Assumes: Inputs change on the falling edge
// Notes:   Wire levels resolved from the core's output enables
`timescale 1ns/1ps
`default_nettype none
module tb_spi_master_slave_core;
    import spi_core_pkg::*;
    logic       clock, got_b;
    logic       rstn = 1'b0, tx_valid = 1'b0, rx_read = 1'b0, fault_clear = 1'b0;
    logic       stop_light = 1'b0, stop_deep = 1'b0, m_sck = 1'b0, m_mosi = 1'b0, m_ss_n = 1'b1, s_miso, tx_ready;
    logic [7:0] tx_data = 8'h00, rx_data, s_rx, got, s_tx = 8'h2D;
    cfg_t       cfg = '0;
    pin_t       pins_o, pins_oe;
    status_t    st;
    int         err_count = 0, checks = 0, n;
    wire pin_t  pins_i = {pins_oe.shift_clock_pin ? pins_o.shift_clock_pin : m_sck,
                          pins_oe.mosi ? pins_o.mosi : m_mosi, pins_oe.miso ? pins_o.miso : s_miso,
                          pins_oe.select_n ? pins_o.select_n : m_ss_n};
    spi_master_slave_core #(.FIFO_DEPTH_P(32)) spi_master_slave_core_i (.clock_i(clock), .rstn_i(rstn),
        .cfg_i(cfg), .pins_i(pins_i), .pins_o(pins_o), .pins_oe_o(pins_oe), .tx_data_i(tx_data),
        .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_read_i(rx_read),
        .fault_clear_i(fault_clear), .status_o(st), .stop_light_i(stop_light), .stop_deep_i(stop_deep));
    spi_slave_model spi_slave_model_i (.sck_i(pins_i.shift_clock_pin), .mosi_i(pins_i.mosi),
        .ss_n_i(pins_i.select_n), .tx_byte_i(s_tx), .miso_o(s_miso), .rx_byte_o(s_rx));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ***************************************************************
    // Access and compare tasks
    // ***************************************************************
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] b);
        @(negedge clock);
        tx_data = b;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1) @(negedge clock);
        @(negedge clock);
        tx_valid = 1'b0;
    endtask
    task automatic rd();
        @(negedge clock);
        rx_read = 1'b1;
        @(negedge clock);
        rx_read = 1'b0;
        @(negedge clock);
    endtask
    task automatic quiet();
        int q;
        q = 0;
        while (q < 20) begin
            @(negedge clock);
            q = (st.busy === 1'b0) ? q + 1 : 0;
        end
    endtask
    task automatic sxfer(input logic [7:0] b);
        m_ss_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            m_mosi = b[i];
            repeat (16) @(negedge clock);
            m_sck = 1'b1;
            got[i] = pins_i.miso;
            repeat (16) @(negedge clock);
            m_sck = 1'b0;
        end
        repeat (16) @(negedge clock);
        m_ss_n = 1'b1;
        m_mosi = ~m_mosi;
    endtask
    task automatic wrap_up();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        wrap_up();
    end
    // ***************************************************************
    // Scenarios
    // ***************************************************************
    initial begin
        repeat (3) @(negedge clock);
        rstn = 1'b1;
        chk("tx_empty", 8'h01, {7'h0, st.transmit_empty_flag});
        chk("oe", 8'h00, {4'h0, pins_oe});
        for (int k = 0; k < 2; k++) begin
            cfg = '{unit_enable: 1'b1, master_select: 1'b1, fault_detect_enable: 1'b1, select_output_enable: 1'b1,
                    lsb_first_select: k[0], prescale_field: k ? 3'h0 : 3'h1, rate_select_field: k ? 3'h3 : 3'h1,
                    default: '0};
            wr(8'hC1);
            while (pins_o.shift_clock_pin === 1'b0) @(negedge clock);
            n = 0;
            while (pins_o.shift_clock_pin === 1'b1) begin
                @(negedge clock);
                n++;
            end
            chk("half_bit", k ? 8'h08 : 8'h04, n[7:0]);
            quiet();
            chk("slave_rx", k ? 8'h83 : 8'hC1, s_rx);
            chk("rx_data", k ? 8'hB4 : 8'h2D, rx_data);
            chk("rx_full", 8'h01, {7'h0, st.receive_full_flag});
            rd();
            chk("rx_full", 8'h00, {7'h0, st.receive_full_flag});
        end
        wr(8'h11);
        wr(8'h81);
        repeat (20) @(negedge clock);
        stop_light = 1'b1;
        repeat (30) @(negedge clock);
        stop_light = 1'b0;
        quiet();
        chk("slave_rx", 8'h81, s_rx);
        chk("rx_data", 8'hB4, rx_data);
        wr(8'h55);
        repeat (10) @(negedge clock);
        stop_deep = 1'b1;
        @(negedge clock);
        stop_deep = 1'b0;
        @(negedge clock);
        chk("rx_full", 8'h00, {7'h0, st.receive_full_flag});
        wr(8'h55);
        repeat (10) @(negedge clock);
        cfg.unit_enable = 1'b0;
        repeat (2) @(negedge clock);
        chk("busy", 8'h00, {7'h0, st.busy});
        chk("tx_empty", 8'h01, {7'h0, st.transmit_empty_flag});
        for (int m = 0; m < 4; m++) begin
            cfg = '{unit_enable: 1'b1, master_select: m[0], single_wire_select: m[1], clock_polarity: m[1],
                    single_wire_drive_enable: 1'b1, default: '0};
            repeat (3) @(negedge clock);
            chk("oe", m[0] ? 8'h0C : 8'h00, {4'h0, pins_oe & 4'hD});
            got_b = m[1];
            if (m[0]) chk("idle_clock", {7'h0, got_b}, {7'h0, pins_o.shift_clock_pin});
        end
        cfg = '{unit_enable: 1'b1, master_select: 1'b1, fault_detect_enable: 1'b1, default: '0};
        m_ss_n = 1'b0;
        repeat (5) @(negedge clock);
        m_ss_n = 1'b1;
        repeat (4) @(negedge clock);
        chk("mode_fault", 8'h01, {7'h0, st.mode_fault_flag});
        fault_clear = 1'b1;
        @(negedge clock);
        fault_clear = 1'b0;
        @(negedge clock);
        chk("mode_fault", 8'h00, {7'h0, st.mode_fault_flag});
        cfg = '{unit_enable: 1'b1, default: '0};
        wr(8'h96);
        repeat (10) @(negedge clock);
        sxfer(8'h5A);
        repeat (5) @(negedge clock);
        chk("slave_miso", 8'h96, got);
        chk("rx_data", 8'h5A, rx_data);
        wrap_up();
    end
endmodule // tb_spi_master_slave_core
`default_nettype wire
